// [mdio_mgmt_and_clock_output_tb_top.sv]
`timescale 1ns/1ps
module mdio_mgmt_and_clock_output_tb_top;
    import mmc_pkg::*;
    localparam logic [4:0] PHY = 5'h0b;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        mdc, mdio_wire, mdio_out, mdio_oe_n, drv_en, drv_val;
    logic [1:0]  refp = 2'b00;
    logic [1:0]  hs_clk = 2'b00;
    logic [1:0]  osc_clk = 2'b00;
    logic        c_lh = 1'b0;
    logic        c_ll = 1'b0;
    logic        c_live = 1'b0;
    logic        err_ev = 1'b0;
    logic        ck_a, ck_b, ck_a_q, ck_b_q, half_spd, dp_rst, dp_seen;
    logic [1:0]  ref_sel, strobe, strobe_seen, ta;
    logic [15:0] hs_data, wdat, rv;
    logic [15:0] gsel [3] = '{16'h0610, 16'h1610, 16'h1e10};
    logic [1:0]  sexp [3] = '{2'b01, 2'b10, 2'b11};
    logic [15:0] ckcfg [3] = '{16'h0000, 16'h0011, 16'h0018};
    int          ckexp [3] = '{50, 50, 4};
    int          err_count, n_tests, cyc, na, nb, i;
    always #2 mclk = ~mclk;
    // Shared line with pull-up; either side drives both levels, and the DUT's driver wins over the station's
    assign mdio_wire = !mdio_oe_n ? mdio_out : (drv_en ? drv_val : 1'b1);
    always @(negedge mclk) begin
        cyc++;
        hs_clk = {2{cyc[3]}};
        osc_clk = {2{cyc[2]}};
    end
    always @(posedge mclk) begin
        strobe_seen |= strobe;
        dp_seen |= dp_rst;
        na += int'(ck_a && !ck_a_q);
        nb += int'(ck_b && !ck_b_q);
        ck_a_q = ck_a;
        ck_b_q = ck_b;
    end
    mmc_mgmt mmc_mgmt_i (
        .mclk(mclk), .rst(rst), .mdc(mdc), .mdio_in(mdio_wire), .mdio_out(mdio_out),
        .mdio_oe_n(mdio_oe_n), .port_address_pins(PHY), .ref_select_pins(refp),
        .hs_recovered_byte_clock(hs_clk), .oscillator_half_clock(osc_clk),
        .cond_latch_high(c_lh), .cond_latch_low(c_ll), .cond_live(c_live),
        .err_event(err_ev), .clock_output_pair_a(ck_a), .clock_output_pair_b(ck_b),
        .ref_sel(ref_sel), .half_speed_mode(half_spd), .datapath_reset(dp_rst),
        .hs_wr_strobe(strobe), .hs_wr_data(hs_data));
    mmc_station mmc_station_i (
        .mclk(mclk), .mdio_wire(mdio_wire), .mdc(mdc), .drv_en(drv_en), .drv_val(drv_val));
    // ****
    // Access tasks
    // ****
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] r;
        logic [1:0]  t;
        mmc_station_i.frame(1'b0, PHY, a, d, r, t);
    endtask : wr
    task automatic rd_chk(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
        logic [15:0] d;
        logic [1:0]  t;
        mmc_station_i.frame(1'b1, PHY, a, 16'h0000, d, t);
        check("turnaround", {14'h0, t}, 16'h0002);
        check($sformatf("reg %h", a), d & m, e);
    endtask : rd_chk
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    initial begin
        #360000;
        err_count++;
        tally_and_finish();
    end
    // ****
    // Tests
    // ****
    initial begin
        repeat (20) @(negedge mclk);
        rst = 1'b0;
        repeat (4) @(negedge mclk);
        rd_chk(5'h00, 16'hffff, 16'h0610);
        rd_chk(5'h15, 16'hffff, 16'h0000);
        wr(5'h05, 16'h1234);
        rd_chk(5'h05, 16'hffff, 16'h0000);
        wr(5'h00, 16'h6610);
        rd_chk(5'h00, 16'hffff, 16'h0610);
        for (i = 0; i < 3; i++) begin
            wr(5'h00, gsel[i]);
            strobe_seen = 2'b00;
            wdat = 16'h0013 + 16'(i);
            wr(5'h15, wdat);
            check("strobe", {14'h0, strobe_seen}, {14'h0, sexp[i]});
            check("hs data", hs_data, wdat);
        end
        rd_chk(5'h15, 16'hffff, 16'h0015);
        mmc_station_i.frame(1'b0, PHY ^ 5'h01, 5'h15, 16'h0007, rv, ta);
        rd_chk(5'h15, 16'hffff, 16'h0015);
        mmc_station_i.frame(1'b1, PHY ^ 5'h10, 5'h15, 16'h0000, rv, ta);
        check("foreign read", rv, 16'hffff);
        // Indirect pointer first, then the window
        wr(5'h1e, 16'h8003);
        wr(5'h1f, 16'hbeef);
        wr(5'h1e, 16'h8000);
        wr(5'h1f, 16'h1234);
        wr(5'h1e, 16'h8003);
        rd_chk(5'h1f, 16'hffff, 16'hbeef);
        rd_chk(5'h1e, 16'hffff, 16'h8003);
        wr(5'h1e, 16'h8008);
        wr(5'h1f, 16'h5555);
        rd_chk(5'h1f, 16'hffff, 16'h0000);
        wr(5'h1e, 16'h8000);
        rd_chk(5'h1f, 16'hffff, 16'h1234);
        rd_chk(5'h16, 16'h0007, 16'h0002);
        c_lh = 1'b1;
        c_ll = 1'b1;
        c_live = 1'b1;
        repeat (8) @(negedge mclk);
        c_lh = 1'b0;
        c_ll = 1'b0;
        rd_chk(5'h16, 16'h0007, 16'h0005);
        rd_chk(5'h16, 16'h0007, 16'h0006);
        wr(5'h16, 16'h0000);
        c_live = 1'b0;
        rd_chk(5'h16, 16'h0007, 16'h0002);
        for (i = 0; i < 3; i++) begin
            err_ev = 1'b1;
            repeat (6) @(negedge mclk);
            err_ev = 1'b0;
            repeat (6) @(negedge mclk);
        end
        rd_chk(5'h17, 16'hffff, 16'h0003);
        wr(5'h17, 16'h0055);
        rd_chk(5'h17, 16'hffff, 16'h0000);
        // Half-speed oversampling set up by software
        wr(5'h02, 16'h0009);
        check("ref sel", {14'h0, ref_sel}, 16'h0001);
        check("half speed", {15'h0, half_spd}, 16'h0001);
        refp = 2'b10;
        wr(5'h02, 16'h0004);
        check("ref pins", {14'h0, ref_sel}, 16'h0002);
        for (i = 0; i < 3; i++) begin
            wr(5'h15, ckcfg[i]);
            na = 0;
            nb = 0;
            repeat (800) @(negedge mclk);
            check("clkout a", 16'(na >= ckexp[i] - 1 && na <= ckexp[i] + 1), 16'h0001);
            check("clkout b", 16'(nb >= ckexp[i] - 1 && nb <= ckexp[i] + 1), 16'h0001);
        end
        dp_seen = 1'b0;
        wr(5'h00, 16'h8610);
        check("soft reset", {15'h0, dp_seen}, 16'h0001);
        rd_chk(5'h00, 16'hffff, 16'h0610);
        rd_chk(5'h15, 16'hffff, 16'h0000);
        tally_and_finish();
    end
endmodule : mdio_mgmt_and_clock_output_tb_top

// [mmc_checker.sv]
`timescale 1ns/1ps
module mmc_checker (
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic       mdc,
    input wire logic       mdio_out,
    input wire logic       mdio_oe_n,
    input wire logic       clock_output_pair_a,
    input wire logic       clock_output_pair_b,
    input wire logic       datapath_reset,
    input wire logic [1:0] hs_wr_strobe
);
    // ****
    // Drive span
    // ****
    // The second turnaround bit plus 16 data bits, and one bit spare, at the bench's slowest management clock
    localparam int MAX_DRIVE = 360;
    int drive_cnt;
    always_ff @(posedge mclk) begin
        if (rst || mdio_oe_n)
            drive_cnt <= 0;
        else
            drive_cnt <= drive_cnt + 1;
    end
    sequence s_ta_low;
        !mdio_oe_n && !mdio_out;
    endsequence
    sequence s_quiet;
        mdio_oe_n && mdio_out && datapath_reset;
    endsequence
    a_reset_quiet: assert property (@(posedge mclk) rst |=> s_quiet)
        else $error("pins not idle in reset");
    a_clk_quiet: assert property (@(posedge mclk)
        rst |=> !clock_output_pair_a && !clock_output_pair_b)
        else $error("clock outputs run in reset");
    a_ta_first: assert property (@(posedge mclk) disable iff (rst)
        $fell(mdio_oe_n) |-> s_ta_low)
        else $error("first driven bit not zero");
    a_drive_span: assert property (@(posedge mclk) disable iff (rst)
        drive_cnt <= MAX_DRIVE)
        else $error("drive lasts too long");
    a_enable_low_mdc: assert property (@(posedge mclk) disable iff (rst)
        $changed(mdio_oe_n) |-> !mdc)
        else $error("enable moved while clock high");
    a_data_low_mdc: assert property (@(posedge mclk) disable iff (rst)
        !mdio_oe_n && $changed(mdio_out) |-> !mdc)
        else $error("data moved while clock high");
    a_strobe_pulse: assert property (@(posedge mclk) disable iff (rst)
        hs_wr_strobe != 2'b00 |=> hs_wr_strobe == 2'b00)
        else $error("strobe longer than a cycle");
    a_strobe_quiet: assert property (@(posedge mclk) disable iff (rst)
        hs_wr_strobe != 2'b00 |-> mdio_oe_n && !datapath_reset)
        else $error("strobe outside a write");
    a_soft_pulse: assert property (@(posedge mclk) disable iff (rst)
        datapath_reset && !$past(rst) |=> !datapath_reset)
        else $error("soft reset not one cycle");
endmodule : mmc_checker

bind mmc_mgmt mmc_checker mmc_checker_i (
    .mclk(mclk), .rst(rst), .mdc(mdc), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
    .clock_output_pair_a(clock_output_pair_a), .clock_output_pair_b(clock_output_pair_b),
    .datapath_reset(datapath_reset), .hs_wr_strobe(hs_wr_strobe));

// [mmc_clkdiv.sv]
`timescale 1ns/1ps
`include "mmc_params.svh"
module mmc_clkdiv
    import mmc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        src_rec,
    input  wire logic        src_osc,
    input  wire mmc_clkcfg_t cfg,
    output logic             clk_out
);
    // Sources are sampled as levels; edges counted on mclk.
    // Limits usable source rate to below mclk/2.
    logic       s_rec;
    logic       s_osc;
    logic       src_d;
    logic [4:0] cnt;
    logic [4:0] ratio;
    wire        src_now = cfg.src_osc ? s_osc : s_rec;
    wire        rise    = src_now & ~src_d;

    mmc_sync #(.W(2)) u_sync (
        .mclk (mclk),
        .rst  (rst),
        .din  ({src_osc, src_rec}),
        .dout ({s_osc, s_rec})
    );

    // Encoded ratios 1,2,4,5,8,10,16,20,25
    always_comb begin
        case (cfg.div_sel)
            4'h0:    ratio = 5'd1;
            4'h1:    ratio = 5'd2;
            4'h2:    ratio = 5'd4;
            4'h3:    ratio = 5'd5;
            4'h4:    ratio = 5'd8;
            4'h5:    ratio = 5'd10;
            4'h6:    ratio = 5'd16;
            4'h7:    ratio = 5'd20;
            4'h8:    ratio = 5'd25;
            default: ratio = 5'd1;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            src_d   <= 1'b0;
            cnt     <= 5'd0;
            clk_out <= 1'b0;
        end else begin
            src_d <= src_now;
            if (ratio == 5'd1) begin
                clk_out <= src_now;
            end else if (rise) begin
                if (cnt >= ratio - 5'd1) begin
                    cnt <= 5'd0;
                end else begin
                    cnt <= cnt + 5'd1;
                end
                // Odd ratios give a slightly uneven duty
                clk_out <= (cnt < (ratio >> 1));
            end
        end
    end
endmodule : mmc_clkdiv

// [mmc_mgmt.sv]
`timescale 1ns/1ps
`include "mmc_params.svh"
module mmc_mgmt
    import mmc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        mdc,
    input  wire logic        mdio_in,
    output logic             mdio_out,
    output logic             mdio_oe_n,
    input  wire logic [4:0]  port_address_pins,
    input  wire logic [1:0]  ref_select_pins,
    input  wire logic [1:0]  hs_recovered_byte_clock,
    input  wire logic [1:0]  oscillator_half_clock,
    input  wire logic        cond_latch_high,
    input  wire logic        cond_latch_low,
    input  wire logic        cond_live,
    input  wire logic        err_event,
    output logic             clock_output_pair_a,
    output logic             clock_output_pair_b,
    output logic [1:0]       ref_sel,
    output logic             half_speed_mode,
    output logic             datapath_reset,
    output logic [1:0]       hs_wr_strobe,
    output logic [15:0]      hs_wr_data
);
    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic       s_mdc;
    logic       s_mdio;
    logic [4:0] s_prtad;
    logic [1:0] s_refpin;
    logic       s_lh;
    logic       s_ll;
    logic       s_live;
    logic       s_err;

    mmc_sync #(.W(13)) u_sync (
        .mclk (mclk),
        .rst  (rst),
        .din  ({mdc, mdio_in, port_address_pins, ref_select_pins,
                cond_latch_high, cond_latch_low, cond_live, err_event}),
        .dout ({s_mdc, s_mdio, s_prtad, s_refpin, s_lh, s_ll, s_live, s_err})
    );

    // ************************************************************
    // Frame engine
    // ************************************************************
    mmc_state_t  state;
    mmc_state_t  next_state;
    logic        mdc_d;
    logic [5:0]  ones;
    logic [4:0]  bcnt;
    logic        is_read;
    logic        match;
    logic [4:0]  regad;
    logic [15:0] shreg;
    logic [15:0] rdata;
    logic        soft_rst;
    logic        err_d;
    mmc_req_t    req;

    wire mdc_rise = s_mdc & ~mdc_d;
    wire mdc_fall = ~s_mdc & mdc_d;
    wire any_rst  = rst | soft_rst;

    always_comb begin
        next_state = state;
        case (state)
            MMC_IDLE:   next_state = (ones >= `MMC_PRE_LEN && !s_mdio) ? MMC_START : MMC_IDLE;
            MMC_START:  next_state = s_mdio ? MMC_OPCODE : MMC_IDLE;
            MMC_OPCODE: next_state = (bcnt == 5'd1) ? MMC_PHYAD : MMC_OPCODE;
            MMC_PHYAD:  next_state = (bcnt == `MMC_ADDR_LAST) ? MMC_REGAD : MMC_PHYAD;
            MMC_REGAD:  next_state = (bcnt == `MMC_ADDR_LAST) ? MMC_TA : MMC_REGAD;
            MMC_TA:     next_state = (bcnt == 5'd1) ? MMC_DATA : MMC_TA;
            MMC_DATA:   next_state = (bcnt == `MMC_DATA_LAST) ? MMC_IDLE : MMC_DATA;
            default:    next_state = MMC_IDLE;
        endcase
    end

    wire last_bit = (bcnt == `MMC_DATA_LAST);
    wire field_end = (state != next_state);
    wire [4:0] regad_nx = {regad[3:0], s_mdio};

    always_ff @(posedge mclk) begin
        if (any_rst) begin
            state   <= MMC_IDLE;
            // Follow the pin so a soft reset under a high clock makes no false edge
            mdc_d   <= s_mdc;
            ones    <= 6'd0;
            bcnt    <= 5'd0;
            is_read <= 1'b0;
            match   <= 1'b0;
            regad   <= 5'd0;
            shreg   <= 16'h0000;
        end else begin
            mdc_d <= s_mdc;
            if (mdc_rise) begin
                state <= next_state;
                bcnt  <= field_end ? 5'd0 : bcnt + 5'd1;
                ones  <= s_mdio ? ((ones == `MMC_PRE_LEN) ? ones : ones + 6'd1) : 6'd0;
                case (state)
                    MMC_OPCODE: is_read <= (bcnt == 5'd0) ? s_mdio : is_read;
                    MMC_PHYAD:  begin
                        shreg <= {shreg[14:0], s_mdio};
                        if (bcnt == `MMC_ADDR_LAST) begin
                            match <= ({shreg[3:0], s_mdio} == s_prtad);
                        end
                    end
                    MMC_REGAD:  regad <= regad_nx;
                    MMC_TA:     shreg <= rdata;
                    MMC_DATA:   shreg <= {shreg[14:0], s_mdio};
                    default:    begin end
                endcase
                if (state == MMC_START) begin
                    ones <= 6'd0;
                end
            end
        end
    end

    // Write request and read strobe both on the last data bit
    assign req.wr    = mdc_rise && state == MMC_DATA && last_bit && match && !is_read;
    assign req.rd    = mdc_rise && state == MMC_DATA && last_bit && match && is_read;
    assign req.regad = regad;
    assign req.wdata = {shreg[14:0], s_mdio};

    // ************************************************************
    // Read driver
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (any_rst) begin
            mdio_out  <= 1'b1;
            mdio_oe_n <= 1'b1;
        end else if (mdc_fall) begin
            if (match && is_read && state == MMC_TA && bcnt == 5'd1) begin
                mdio_oe_n <= 1'b0;
                mdio_out  <= 1'b0;
            end else if (match && is_read && state == MMC_DATA) begin
                mdio_oe_n <= 1'b0;
                mdio_out  <= shreg[15];
            end else begin
                mdio_oe_n <= 1'b1;
                mdio_out  <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    logic        macro_sel;
    logic        bcast;
    logic [3:0]  gbl_rsv;
    logic [4:0]  gbl_ovl;
    logic [15:0] clkout_ctrl;
    logic [15:0] ind_addr;
    logic [15:0] ls_ctrl;
    logic        lh_bit;
    logic        ll_bit;
    logic [15:0] err_cnt;
    logic [15:0] ext_mem [`MMC_EXT_DEPTH];

    wire hit_gbl  = req.regad == `MMC_REG_GLOBAL;
    wire hit_cko  = req.regad == `MMC_REG_CLKOUT;
    wire hit_ls   = req.regad == `MMC_REG_LS_CTRL;
    wire hit_st   = req.regad == `MMC_REG_STATUS;
    wire hit_cnt  = req.regad == `MMC_REG_ERRCNT;
    wire hit_ia   = req.regad == `MMC_REG_IND_ADDR;
    wire hit_id   = req.regad == `MMC_REG_IND_DATA;
    wire rd_at    = mdc_rise && state == MMC_TA && bcnt == 5'd1 && match && is_read;
    wire rd_st    = rd_at && regad == `MMC_REG_STATUS;
    wire rd_cnt   = rd_at && regad == `MMC_REG_ERRCNT;
    wire ext_ok   = ind_addr[15:`MMC_EXT_IDX_W] == `MMC_EXT_BASE >> `MMC_EXT_IDX_W;
    wire [`MMC_EXT_IDX_W-1:0] ext_idx = ind_addr[`MMC_EXT_IDX_W-1:0];
    wire err_rise = s_err & ~err_d;

    // Read mux, evaluated at the turnaround
    always_comb begin
        case (regad)
            `MMC_REG_GLOBAL:   rdata = {1'b0, 2'b00, macro_sel, bcast, gbl_rsv, 2'b00, gbl_ovl};
            `MMC_REG_CLKOUT:   rdata = clkout_ctrl;
            `MMC_REG_LS_CTRL:  rdata = ls_ctrl;
            `MMC_REG_STATUS:   rdata = {13'h0000, s_live, ll_bit, lh_bit};
            `MMC_REG_ERRCNT:   rdata = err_cnt;
            `MMC_REG_IND_ADDR: rdata = ind_addr;
            `MMC_REG_IND_DATA: rdata = ext_ok ? ext_mem[ext_idx] : 16'h0000;
            default:           rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (any_rst) begin
            macro_sel   <= 1'b0;
            bcast       <= 1'b0;
            gbl_rsv     <= `MMC_GBL_RSV_RST;
            gbl_ovl     <= `MMC_GBL_OVL_RST;
            clkout_ctrl <= `MMC_CKO_RST;
            ind_addr    <= 16'h0000;
            ls_ctrl     <= 16'h0000;
        end else if (req.wr) begin
            if (hit_gbl) begin
                macro_sel <= req.wdata[`MMC_GBL_MACRO_BIT];
                bcast     <= req.wdata[`MMC_GBL_BCAST_BIT];
                gbl_rsv   <= req.wdata[`MMC_GBL_RSV_HI:`MMC_GBL_RSV_LO];
                gbl_ovl   <= req.wdata[`MMC_GBL_OVL_HI:`MMC_GBL_OVL_LO];
            end
            if (hit_cko) clkout_ctrl <= req.wdata;
            if (hit_ls)  ls_ctrl     <= req.wdata;
            if (hit_ia)  ind_addr    <= req.wdata;
        end
    end

    generate
        for (genvar i = 0; i < `MMC_EXT_DEPTH; i++) begin : g_ext
            always_ff @(posedge mclk) begin
                if (any_rst) begin
                    ext_mem[i] <= 16'h0000;
                end else if (req.wr && hit_id && ext_ok && ext_idx == i) begin
                    ext_mem[i] <= req.wdata;
                end
            end
        end
    endgenerate

    // Set wins over the read-clear
    always_ff @(posedge mclk) begin
        if (any_rst) begin
            lh_bit  <= 1'b0;
            ll_bit  <= 1'b1;
            err_cnt <= 16'h0000;
            err_d   <= 1'b0;
        end else begin
            err_d  <= s_err;
            lh_bit <= s_lh | (lh_bit & ~rd_st);
            ll_bit <= ~s_ll & (ll_bit | rd_st);
            if (err_rise) begin
                err_cnt <= rd_cnt ? 16'h0001 :
                           (err_cnt == `MMC_CNT_MAX) ? err_cnt : err_cnt + 16'h0001;
            end else if (rd_cnt) begin
                err_cnt <= 16'h0000;
            end
        end
    end

    // Soft reset: only the external reset clears the pulse itself
    always_ff @(posedge mclk) begin
        if (rst) begin
            soft_rst <= 1'b0;
        end else begin
            soft_rst <= req.wr && hit_gbl && req.wdata[`MMC_GBL_RESET_BIT];
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            datapath_reset  <= 1'b1;
            hs_wr_strobe    <= 2'b00;
            hs_wr_data      <= 16'h0000;
            ref_sel         <= 2'b00;
            half_speed_mode <= 1'b0;
        end else begin
            datapath_reset <= soft_rst;
            // Held between writes; the shift register moves on every PHY address and data bit
            if (req.wr && hit_cko) begin
                hs_wr_data <= req.wdata;
            end
            hs_wr_strobe   <= (req.wr && hit_cko) ?
                              (bcast ? 2'b11 : (macro_sel ? 2'b10 : 2'b01)) : 2'b00;
            ref_sel[0]     <= ls_ctrl[`MMC_LS_REFPIN] ? s_refpin[0] : ls_ctrl[`MMC_LS_REFSEL_A];
            ref_sel[1]     <= ls_ctrl[`MMC_LS_REFPIN] ? s_refpin[1] : ls_ctrl[`MMC_LS_REFSEL_B];
            half_speed_mode <= ls_ctrl[`MMC_LS_HALFSPD];
        end
    end

    mmc_clkdiv u_div_a (
        .mclk    (mclk),
        .rst     (any_rst),
        .src_rec (hs_recovered_byte_clock[0]),
        .src_osc (oscillator_half_clock[0]),
        .cfg     ({clkout_ctrl[`MMC_CKO_SRC_BIT], clkout_ctrl[`MMC_CKO_DIV_HI:`MMC_CKO_DIV_LO]}),
        .clk_out (clock_output_pair_a)
    );

    mmc_clkdiv u_div_b (
        .mclk    (mclk),
        .rst     (any_rst),
        .src_rec (hs_recovered_byte_clock[1]),
        .src_osc (oscillator_half_clock[1]),
        .cfg     ({clkout_ctrl[`MMC_CKO_SRC_BIT], clkout_ctrl[`MMC_CKO_DIV_HI:`MMC_CKO_DIV_LO]}),
        .clk_out (clock_output_pair_b)
    );
endmodule : mmc_mgmt

// [mmc_params.svh]
`ifndef MMC_PARAMS_SVH
`define MMC_PARAMS_SVH

// Register map (direct register numbers)
`define MMC_REG_GLOBAL      5'h00
`define MMC_REG_CLKOUT      5'h15
`define MMC_REG_STATUS      5'h16
`define MMC_REG_ERRCNT      5'h17
`define MMC_REG_IND_ADDR    5'h1e
`define MMC_REG_IND_DATA    5'h1f
`define MMC_REG_LS_CTRL     5'h02

// Extended register space
`define MMC_EXT_BASE        16'h8000
`define MMC_EXT_DEPTH       8
`define MMC_EXT_IDX_W       3

// Field positions in the global control register
`define MMC_GBL_RESET_BIT   15
`define MMC_GBL_MACRO_BIT   12
`define MMC_GBL_BCAST_BIT   11
`define MMC_GBL_RSV_HI      10
`define MMC_GBL_RSV_LO      7
`define MMC_GBL_OVL_HI      4
`define MMC_GBL_OVL_LO      0
`define MMC_GBL_RSV_RST     4'hc
`define MMC_GBL_OVL_RST     5'h10

// Clock output control fields
`define MMC_CKO_SRC_BIT     4
`define MMC_CKO_DIV_HI      3
`define MMC_CKO_DIV_LO      0
`define MMC_CKO_RST         16'h0000

// Low-speed control fields
`define MMC_LS_REFSEL_A     0
`define MMC_LS_REFSEL_B     1
`define MMC_LS_REFPIN       2
`define MMC_LS_HALFSPD      3

// Status bits
`define MMC_ST_LH_BIT       0
`define MMC_ST_LL_BIT       1
`define MMC_ST_LIVE_BIT     2

// Frame fields
`define MMC_PRE_LEN         6'd32
`define MMC_OP_READ         2'b10
`define MMC_OP_WRITE        2'b01
`define MMC_DATA_LAST       5'd15
`define MMC_ADDR_LAST       5'd4
`define MMC_CNT_MAX         16'hffff

`endif

// [mmc_pkg.sv]
package mmc_pkg;
    typedef enum logic [2:0] {
        MMC_IDLE, MMC_START, MMC_OPCODE, MMC_PHYAD, MMC_REGAD, MMC_TA, MMC_DATA
    } mmc_state_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [4:0]  regad;
        logic [15:0] wdata;
    } mmc_req_t;

    typedef struct packed {
        logic       src_osc;
        logic [3:0] div_sel;
    } mmc_clkcfg_t;
endpackage : mmc_pkg

// [mmc_station.sv]
`timescale 1ns/1ps
module mmc_station #(
    parameter int HALF = 10
) (
    input  wire logic mclk,
    input  wire logic mdio_wire,
    output logic      mdc,
    output logic      drv_en,
    output logic      drv_val
);
    // Clock stands low between frames
    initial begin
        mdc = 1'b0;
        drv_en = 1'b0;
        drv_val = 1'b1;
    end
    task automatic bit_cell(input logic en, input logic v, output logic seen);
        drv_en = en;
        drv_val = v;
        repeat (HALF) @(negedge mclk);
        mdc = 1'b1;
        seen = mdio_wire;
        repeat (HALF) @(negedge mclk);
        mdc = 1'b0;
    endtask : bit_cell
    task automatic frame(input logic rd, input logic [4:0] phy, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rdat,
                         output logic [1:0] ta);
        logic [13:0] hdr;
        logic        s;
        int          i;
        hdr = {2'b01, rd ? 2'b10 : 2'b01, phy, ra};
        for (i = 0; i < 32; i++)
            bit_cell(1'b1, 1'b1, s);
        for (i = 13; i >= 0; i--)
            bit_cell(1'b1, hdr[i], s);
        // Released on reads: the pull-up alone holds the first bit
        bit_cell(!rd, 1'b1, ta[1]);
        bit_cell(!rd, 1'b0, ta[0]);
        for (i = 15; i >= 0; i--) begin
            bit_cell(!rd, wd[i], s);
            rdat[i] = s;
        end
        drv_en = 1'b0;
        repeat (2 * HALF) @(negedge mclk);
    endtask : frame
endmodule : mmc_station

// [mmc_sync.sv]
`timescale 1ns/1ps
module mmc_sync
    import mmc_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge mclk) begin
        if (rst) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule : mmc_sync
